// file: bench/pdc_asserts.sv
// checker for pdc_top: bus handshake, timer control bit 7 read mask, unit 1 pin gating and enable.
// assumes one clock with synchronous active-high reset; bound to pdc_top.
`timescale 1ns/1ps
module pdc_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pdc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins
    input wire logic unit1_pin_o,
    input wire logic unit1_pin_oe_o
);
    // ----
    // mirrors taken at the request edge, early so pin checks never lead the design
    // ----
    logic req;
    logic wr_req;
    logic rd_tc;
    logic pwm1_q;
    logic dir0_q;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = req && wb_we_i && wb_sel_i[0];
    assign rd_tc = req && !wb_we_i && wb_adr_i == pdc_pkg::OFS_PERIOD_TIMER_CONTROL;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm1_q <= 1'b0;
            dir0_q <= 1'b1;
        end else if (wr_req && wb_adr_i == pdc_pkg::OFS_UNIT1_CONTROL) begin
            pwm1_q <= wb_dat_i[3:2] == pdc_pkg::MODE_TOP_PWM;
        end else if (wr_req && wb_adr_i == pdc_pkg::OFS_PIN_DIRECTION) begin
            dir0_q <= wb_dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_answer; req |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause; !req |=> !wb_ack_o; endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_timer_top; rd_tc |=> !wb_dat_o[7]; endproperty
    a_timer_top: assert property (p_timer_top)
        else $error("timer control bit 7 read as one");
    property p_pwm_gate; !pwm1_q && !$past(pwm1_q) |=> !unit1_pin_o; endproperty
    a_pwm_gate: assert property (p_pwm_gate)
        else $error("pin high outside pwm mode");
    property p_rise_pwm;
        $rose(unit1_pin_o) |-> pwm1_q || $past(pwm1_q) || $past(pwm1_q, 2);
    endproperty
    a_rise_pwm: assert property (p_rise_pwm)
        else $error("pin set without pwm mode");
    property p_oe_dir;
        dir0_q == $past(dir0_q) && dir0_q == $past(dir0_q, 2) |-> unit1_pin_oe_o == !dir0_q;
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("pin enable disagrees with direction");
endmodule

bind pdc_top pdc_asserts pdc_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unit1_pin_o(unit1_pin_o),
    .unit1_pin_oe_o(unit1_pin_oe_o)
);

// file: bench/pdc_load.sv
// load on one pwm pin: measures high time, period and rising edges.
// assumes a pull-down on the pin, so a released pin reads low.
`timescale 1ns/1ps
module pdc_load (
    // clock
    input wire logic clk_i,
    // pin and its enable
    input wire logic pin_i,
    input wire logic pin_oe_i,
    // measurements in core clocks
    output int hi_len_o,
    output int per_len_o,
    output int rises_o
);
    logic lvl;
    logic last = 1'b0;
    int hi = 0;
    int per = 0;
    assign lvl = pin_oe_i ? pin_i : 1'b0;
    always @(posedge clk_i) begin
        if (lvl && !last) begin
            per_len_o <= per;
            rises_o <= rises_o + 1;
            per = 1;
            hi = 1;
        end else begin
            per++;
            hi = lvl ? hi + 1 : hi;
        end
        if (!lvl && last) begin
            hi_len_o <= hi;
        end
        last = lvl;
    end
endmodule

// file: bench/pdc_top_tb.sv
// bench for pdc_top: register reads and writes over wishbone, pwm waveforms.
// assumes pdc_pkg offsets; a small-package copy shares the bus inputs.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module pdc_top_tb;
    // ----
    // stimulus tables
    // ----
    localparam logic [5:0] MA [5] = '{6'h08, 6'h20, 6'h14, 6'h24, 6'h28};
    localparam logic [7:0] ML [5] = '{8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] MS [5] = '{8'h7F, 8'h3F, 8'h3F, 8'hFC, 8'h80};
    localparam int CU [4] = '{1, 1, 0, 0};
    localparam logic [1:0] CP [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    localparam logic [7:0] CL [4] = '{8'h01, 8'h00, 8'h02, 8'h03};
    localparam logic [9:0] CD [4] = '{10'h003, 10'h002, 10'h007, 10'h005};
    // high time is duty times prescale plus one registration clock
    localparam int CPER [4] = '{128, 64, 48, 16};
    localparam int CHI [4] = '{49, 33, 29, 6};
    logic clk_i;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [5:0] wb_adr = 6'h00;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] dat_o, dat2_o;
    logic ack, p1, oe1, p2, oe2;
    logic [7:0] rdat, rdat2;
    int miscompares = 0;
    int comparisons = 0;
    int hl1, pl1, rs1, hl2, pl2, rs2, r0;
    pdc_top pdc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .unit1_pin_o(p1), .unit1_pin_oe_o(oe1),
        .unit2_pin_o(p2), .unit2_pin_oe_o(oe2));
    pdc_top #(.LARGE_PKG(1'b0)) pdc_top_s_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dat_o(dat2_o), .wb_ack_o(),
        .unit1_pin_o(), .unit1_pin_oe_o(), .unit2_pin_o(), .unit2_pin_oe_o());
    pdc_load pdc_load_i (.clk_i(clk_i), .pin_i(p1), .pin_oe_i(oe1),
        .hi_len_o(hl1), .per_len_o(pl1), .rises_o(rs1));
    pdc_load pdc_load_u2_i (.clk_i(clk_i), .pin_i(p2), .pin_oe_i(oe2),
        .hi_len_o(hl2), .per_len_o(pl2), .rises_o(rs2));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic test_done;
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= 32'(d);
        @(posedge clk_i);
        // no cycle budget here: only the watchdog ends a wait for ack
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        rdat = dat_o[7:0];
        rdat2 = dat2_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input string n, input logic [5:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        `CHK(n, e, rdat)
    endtask
    task automatic pwm(input int u, input logic [1:0] ps, input logic [7:0] lim,
        input logic [9:0] duty, input logic [1:0] md);
        logic [5:0] b;
        b = 6'(u * 12);
        wr(pdc_pkg::OFS_UNIT1_CONTROL + b, 8'h00);
        wr(pdc_pkg::OFS_PERIOD_TIMER_CONTROL, 8'h00);
        wr(pdc_pkg::OFS_PERIOD_COUNTER, 8'h00);
        wr(pdc_pkg::OFS_PERIOD_LIMIT, lim);
        wr(pdc_pkg::OFS_UNIT1_VALUE_LOW + b, duty[9:2]);
        wr(pdc_pkg::OFS_UNIT1_CONTROL + b, {2'h0, duty[1:0], 4'h0});
        wr(pdc_pkg::OFS_PERIOD_TIMER_CONTROL, {5'h00, 1'b1, ps});
        wr(pdc_pkg::OFS_UNIT1_CONTROL + b, {2'h0, duty[1:0], 2'h3, md});
    endtask
    task automatic meas(input int u, input int per, input int hi);
        int n;
        n = 0;
        r0 = u ? rs2 : rs1;
        while ((u ? rs2 : rs1) < r0 + 3 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        miscompares += (n == 2000);
        `CHK("period", per, (u ? pl2 : pl1))
        `CHK("high", hi, (u ? hl2 : hl1))
    endtask
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("limit_rst", pdc_pkg::OFS_PERIOD_LIMIT, 8'hFF);
        rd("dir_rst", pdc_pkg::OFS_PIN_DIRECTION, 8'h03);
        rd("unmapped", 6'h30, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(MA[i], 8'hFF);
            bus(MA[i], 1'b0, 8'h00);
            `CHK("mask_large", ML[i], rdat)
            `CHK("mask_small", MS[i], rdat2)
            wr(MA[i], 8'h00);
        end
        wr(pdc_pkg::OFS_UNIT1_CONTROL, 8'h0C);
        wr(pdc_pkg::OFS_UNIT1_VALUE_HIGH, 8'h55);
        rd("shadow_ro", pdc_pkg::OFS_UNIT1_VALUE_HIGH, 8'h00);
        wr(pdc_pkg::OFS_UNIT1_CONTROL, 8'h00);
        wr(pdc_pkg::OFS_UNIT1_VALUE_HIGH, 8'h55);
        rd("shadow_rw", pdc_pkg::OFS_UNIT1_VALUE_HIGH, 8'h55);
        wr(pdc_pkg::OFS_PIN_DIRECTION, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pwm(CU[i], CP[i], CL[i], CD[i], 2'(i));
            meas(CU[i], CPER[i], CHI[i]);
        end
        wr(pdc_pkg::OFS_UNIT1_VALUE_LOW, 8'h02);
        meas(0, 16, 10);
        rd("shadow", pdc_pkg::OFS_UNIT1_VALUE_HIGH, 8'h02);
        pwm(0, 2'h0, 8'h03, 10'h000, 2'h0);
        r0 = rs1;
        repeat (64) @(posedge clk_i);
        `CHK("no_set", r0, rs1)
        pwm(0, 2'h0, 8'h03, 10'h011, 2'h0);
        r0 = rs1;
        repeat (64) @(posedge clk_i);
        `CHK("one_rise", r0 + 1, rs1)
        `CHK("stay_high", 1'b1, p1)
        wr(pdc_pkg::OFS_UNIT1_CONTROL, 8'h04);
        repeat (2) @(posedge clk_i);
        `CHK("pin_off", 1'b0, p1)
        test_done();
    end
endmodule

// file: rtl/pdc_duty_unit.sv
// one pwm duty unit: double-buffered duty value, compare and output latch.
// assumes the period timer, its rollover pulse and sub-count bits come from
// the parent, all on the same clock.
`timescale 1ns/1ps

module pdc_duty_unit #(
    parameter int unsigned TIMER_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic pwm_en_i,
    input wire logic [TIMER_W+1:0] duty_i,
    input wire logic rollover_i,
    input wire logic [TIMER_W-1:0] count_i,
    input wire logic [1:0] ext_i,
    // software access to the shadow byte
    input wire logic shadow_we_i,
    input wire logic [TIMER_W-1:0] shadow_wdata_i,
    // results
    output logic [TIMER_W-1:0] shadow_o,
    output logic pin_o
);

    if (TIMER_W < 2 || TIMER_W > 8) begin : g_bad_width
        $error("pdc_duty_unit: TIMER_W must lie in 2..8");
    end

    typedef struct packed {
        logic [TIMER_W-1:0] shadow;
        logic [1:0] latch;
        logic pin;
    } pdc_unit_s;

    pdc_unit_s q, d;

    always_comb begin
        d = q;
        if (!pwm_en_i) begin
            d.pin = 1'b0;
            if (shadow_we_i) begin
                d.shadow = shadow_wdata_i;
            end
        end else if (rollover_i) begin
            // new period wins over a match in the same cycle
            d.shadow = duty_i[TIMER_W+1:2];
            d.latch = duty_i[1:0];
            d.pin = (duty_i != '0);
        end else if ({q.shadow, q.latch} == {count_i, ext_i}) begin
            // a duty beyond the period never matches, so the pin stays high
            d.pin = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign shadow_o = q.shadow;
    assign pin_o = q.pin;

endmodule

// file: rtl/pdc_pkg.sv
// constants shared by the duty-cycle compare block: register map, field
// positions, reset values and the cycle counts of the period timer.
// assumes a 32-bit classic wishbone bus with byte addresses, one register per word.
package pdc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word per register)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFS_PERIOD_COUNTER = 6'h00;
    localparam logic [5:0] OFS_PERIOD_LIMIT = 6'h04;
    localparam logic [5:0] OFS_PERIOD_TIMER_CONTROL = 6'h08;
    localparam logic [5:0] OFS_UNIT1_VALUE_LOW = 6'h0C;
    localparam logic [5:0] OFS_UNIT1_VALUE_HIGH = 6'h10;
    localparam logic [5:0] OFS_UNIT1_CONTROL = 6'h14;
    localparam logic [5:0] OFS_UNIT2_VALUE_LOW = 6'h18;
    localparam logic [5:0] OFS_UNIT2_VALUE_HIGH = 6'h1C;
    localparam logic [5:0] OFS_UNIT2_CONTROL = 6'h20;
    localparam logic [5:0] OFS_AUTO_SHUTDOWN_CONTROL = 6'h24;
    localparam logic [5:0] OFS_RESTART_DEADBAND_CONTROL = 6'h28;
    localparam logic [5:0] OFS_PIN_DIRECTION = 6'h2C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned DUTY_LOW_LSB = 4;
    localparam int unsigned MODE_TOP_LSB = 2;
    localparam int unsigned TIMER_RUN_BIT = 2;
    localparam int unsigned PRESCALE_LSB = 0;
    localparam logic [1:0] MODE_TOP_PWM = 2'h3;
    localparam logic [1:0] PRESCALE_1 = 2'h0;
    localparam logic [1:0] PRESCALE_4 = 2'h1;

    // implemented-bit masks; everything else reads as zero
    localparam logic [7:0] TIMER_CONTROL_MASK = 8'h7F;
    localparam logic [7:0] UNIT2_CONTROL_MASK = 8'h3F;
    localparam logic [7:0] SMALL_UNIT1_CONTROL_MASK = 8'h3F;
    localparam logic [7:0] SMALL_SHUTDOWN_MASK = 8'hFC;
    localparam logic [7:0] SMALL_DEADBAND_MASK = 8'h80;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
    localparam logic [1:0] RST_PIN_OE = 2'h0;

    // ----------------------------------------------------------------
    // timing: one instruction cycle is four core clocks (quarter phases)
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned QUARTERS_PER_INSTR = 4;
    localparam logic [1:0] PHASE_LAST = 2'(QUARTERS_PER_INSTR - 1);
    localparam logic [3:0] PRESC_LAST_1 = 4'h0;
    localparam logic [3:0] PRESC_LAST_4 = 4'h3;
    localparam logic [3:0] PRESC_LAST_16 = 4'hF;

endpackage

// file: rtl/pdc_top.sv
// duty-cycle compare block: shared 8-bit period timer, two pwm duty units
// and the register file behind a classic wishbone slave.
// assumes a synchronous active-high reset and one 250 MHz core clock that
// also serves as the oscillator; no interrupt, no second clock, no buffer.
`timescale 1ns/1ps

module pdc_top #(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pdc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pwm pins
    output logic unit1_pin_o,
    output logic unit1_pin_oe_o,
    output logic unit2_pin_o,
    output logic unit2_pin_oe_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] period_counter;
        logic [7:0] period_limit;
        logic [7:0] period_timer_control;
        logic [7:0] unit1_value_low;
        logic [7:0] unit1_control;
        logic [7:0] unit2_value_low;
        logic [7:0] unit2_control;
        logic [7:0] auto_shutdown_control;
        logic [7:0] restart_deadband_control;
        logic [1:0] pin_oe;
        logic [1:0] phase;
        logic [3:0] presc;
        logic ack;
        logic [31:0] rdata;
    } pdc_top_s;

    pdc_top_s q, d;

    logic [7:0] unit1_shadow;
    logic [7:0] unit2_shadow;
    logic unit1_pin;
    logic unit2_pin;
    logic unit1_pwm;
    logic unit2_pwm;
    logic timer_inc;
    logic rollover;
    logic [1:0] ext;
    logic req;
    logic wr;
    logic [7:0] wbyte;
    // per-unit duty and shadow strobes, named so the instances connect plain nets
    logic [9:0] unit1_duty;
    logic [9:0] unit2_duty;
    logic unit1_shadow_we;
    logic unit2_shadow_we;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the counters below are fixed width, so refuse constants they cannot serve
    if (pdc_pkg::QUARTERS_PER_INSTR != 4) begin : g_bad_quarters
        $error("pdc_top: the quarter phase counter is two bits wide");
    end
    if (pdc_pkg::ADDR_W != 6) begin : g_bad_addr
        $error("pdc_top: the register offsets are six bits wide");
    end
    if (pdc_pkg::PRESC_LAST_4 != 4'h3) begin : g_bad_presc4
        $error("pdc_top: prescale 4 needs a two-bit sub-count");
    end
    if (pdc_pkg::PRESC_LAST_16 != 4'hF) begin : g_bad_presc16
        $error("pdc_top: prescale 16 needs the full four-bit prescaler");
    end
    if (pdc_pkg::DUTY_LOW_LSB > 6) begin : g_bad_duty_field
        $error("pdc_top: duty low bits must sit inside the control byte");
    end
    if (pdc_pkg::MODE_TOP_LSB > 6) begin : g_bad_mode_field
        $error("pdc_top: mode bits must sit inside the control byte");
    end
    if (pdc_pkg::PRESCALE_LSB > 6) begin : g_bad_presc_field
        $error("pdc_top: prescale select must sit inside the timer control byte");
    end
    if (pdc_pkg::TIMER_RUN_BIT > 7) begin : g_bad_run_bit
        $error("pdc_top: run bit must sit inside the timer control byte");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] presc_last(input logic [1:0] sel);
        case (sel)
            pdc_pkg::PRESCALE_1: presc_last = pdc_pkg::PRESC_LAST_1;
            pdc_pkg::PRESCALE_4: presc_last = pdc_pkg::PRESC_LAST_4;
            default: presc_last = pdc_pkg::PRESC_LAST_16;
        endcase
    endfunction

    function automatic logic is_pwm(input logic [7:0] ctrl);
        is_pwm = (ctrl[pdc_pkg::MODE_TOP_LSB +: 2] == pdc_pkg::MODE_TOP_PWM);
    endfunction

    function automatic logic [9:0] duty_of(input logic [7:0] low, input logic [7:0] ctrl);
        duty_of = {low, ctrl[pdc_pkg::DUTY_LOW_LSB +: 2]};
    endfunction

    // ----------------------------------------------------------------
    // timer events
    // ----------------------------------------------------------------
    always_comb begin
        unit1_pwm = is_pwm(q.unit1_control);
        unit2_pwm = is_pwm(q.unit2_control);
        // one tick every four clocks times prescale
        timer_inc = q.period_timer_control[pdc_pkg::TIMER_RUN_BIT]
            && (q.phase == pdc_pkg::PHASE_LAST)
            && (q.presc == presc_last(q.period_timer_control[pdc_pkg::PRESCALE_LSB +: 2]));
        rollover = timer_inc && (q.period_counter == q.period_limit);
        // sub-count resolves the duty to one clock times prescale
        case (q.period_timer_control[pdc_pkg::PRESCALE_LSB +: 2])
            pdc_pkg::PRESCALE_1: ext = q.phase;
            pdc_pkg::PRESCALE_4: ext = q.presc[1:0];
            default: ext = q.presc[3:2];
        endcase
    end

    // ----------------------------------------------------------------
    // bus decode and per-unit wiring
    // ----------------------------------------------------------------
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !q.ack;
        wr = req && wb_we_i && wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        // shadow writes reach a unit in any mode; the unit drops them in pwm mode
        unit1_shadow_we = wr && (wb_adr_i == pdc_pkg::OFS_UNIT1_VALUE_HIGH);
        unit2_shadow_we = wr && (wb_adr_i == pdc_pkg::OFS_UNIT2_VALUE_HIGH);
        unit1_duty = duty_of(q.unit1_value_low, q.unit1_control);
        unit2_duty = duty_of(q.unit2_value_low, q.unit2_control);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = req;
        d.rdata = '0;

        // quarter phase runs free; prescaler only while the timer runs
        d.phase = q.phase + 2'h1;
        if (q.period_timer_control[pdc_pkg::TIMER_RUN_BIT] && q.phase == pdc_pkg::PHASE_LAST) begin
            if (q.presc == presc_last(q.period_timer_control[pdc_pkg::PRESCALE_LSB +: 2])) begin
                d.presc = '0;
            end else begin
                d.presc = q.presc + 4'h1;
            end
        end
        if (timer_inc) begin
            d.period_counter = rollover ? 8'h00 : q.period_counter + 8'h01;
        end

        // software writes, low byte lane only; a counter write beats the tick
        if (wr) begin
            case (wb_adr_i)
                pdc_pkg::OFS_PERIOD_COUNTER: d.period_counter = wbyte;
                pdc_pkg::OFS_PERIOD_LIMIT: d.period_limit = wbyte;
                pdc_pkg::OFS_PERIOD_TIMER_CONTROL:
                    d.period_timer_control = wbyte & pdc_pkg::TIMER_CONTROL_MASK;
                pdc_pkg::OFS_UNIT1_VALUE_LOW: d.unit1_value_low = wbyte;
                pdc_pkg::OFS_UNIT1_CONTROL: begin
                    if (LARGE_PKG) begin
                        d.unit1_control = wbyte;
                    end else begin
                        d.unit1_control = wbyte & pdc_pkg::SMALL_UNIT1_CONTROL_MASK;
                    end
                end
                pdc_pkg::OFS_UNIT2_VALUE_LOW: d.unit2_value_low = wbyte;
                pdc_pkg::OFS_UNIT2_CONTROL:
                    d.unit2_control = wbyte & pdc_pkg::UNIT2_CONTROL_MASK;
                pdc_pkg::OFS_AUTO_SHUTDOWN_CONTROL: begin
                    if (LARGE_PKG) begin
                        d.auto_shutdown_control = wbyte;
                    end else begin
                        d.auto_shutdown_control = wbyte & pdc_pkg::SMALL_SHUTDOWN_MASK;
                    end
                end
                pdc_pkg::OFS_RESTART_DEADBAND_CONTROL: begin
                    if (LARGE_PKG) begin
                        d.restart_deadband_control = wbyte;
                    end else begin
                        d.restart_deadband_control = wbyte & pdc_pkg::SMALL_DEADBAND_MASK;
                    end
                end
                pdc_pkg::OFS_PIN_DIRECTION: d.pin_oe = ~wbyte[1:0];
                default: begin
                end
            endcase
        end

        // reads; unmapped addresses answer zero
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                pdc_pkg::OFS_PERIOD_COUNTER: d.rdata[7:0] = q.period_counter;
                pdc_pkg::OFS_PERIOD_LIMIT: d.rdata[7:0] = q.period_limit;
                pdc_pkg::OFS_PERIOD_TIMER_CONTROL: d.rdata[7:0] = q.period_timer_control;
                pdc_pkg::OFS_UNIT1_VALUE_LOW: d.rdata[7:0] = q.unit1_value_low;
                pdc_pkg::OFS_UNIT1_VALUE_HIGH: d.rdata[7:0] = unit1_shadow;
                pdc_pkg::OFS_UNIT1_CONTROL: d.rdata[7:0] = q.unit1_control;
                pdc_pkg::OFS_UNIT2_VALUE_LOW: d.rdata[7:0] = q.unit2_value_low;
                pdc_pkg::OFS_UNIT2_VALUE_HIGH: d.rdata[7:0] = unit2_shadow;
                pdc_pkg::OFS_UNIT2_CONTROL: d.rdata[7:0] = q.unit2_control;
                pdc_pkg::OFS_AUTO_SHUTDOWN_CONTROL: d.rdata[7:0] = q.auto_shutdown_control;
                pdc_pkg::OFS_RESTART_DEADBAND_CONTROL:
                    d.rdata[7:0] = q.restart_deadband_control;
                pdc_pkg::OFS_PIN_DIRECTION: d.rdata[1:0] = ~q.pin_oe;
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.period_limit <= pdc_pkg::RST_PERIOD_LIMIT;
            q.pin_oe <= pdc_pkg::RST_PIN_OE;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // duty units; neither unit is wired to the shutdown control register
    // ----------------------------------------------------------------
    pdc_duty_unit #(
        .TIMER_W(8)
    ) u_unit1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pwm_en_i(unit1_pwm),
        .duty_i(unit1_duty),
        .rollover_i(rollover),
        .count_i(q.period_counter),
        .ext_i(ext),
        .shadow_we_i(unit1_shadow_we),
        .shadow_wdata_i(wbyte),
        .shadow_o(unit1_shadow),
        .pin_o(unit1_pin)
    );

    pdc_duty_unit #(
        .TIMER_W(8)
    ) u_unit2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pwm_en_i(unit2_pwm),
        .duty_i(unit2_duty),
        .rollover_i(rollover),
        .count_i(q.period_counter),
        .ext_i(ext),
        .shadow_we_i(unit2_shadow_we),
        .shadow_wdata_i(wbyte),
        .shadow_o(unit2_shadow),
        .pin_o(unit2_pin)
    );

    // ----------------------------------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------------------------------
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign unit1_pin_o = unit1_pin;
    assign unit2_pin_o = unit2_pin;
    assign unit1_pin_oe_o = q.pin_oe[0];
    assign unit2_pin_oe_o = q.pin_oe[1];

endmodule
